// File: pkg/ftid_defines.vh
`ifndef FTID_DEFINES_VH
`define FTID_DEFINES_VH
// instruction word layout
`define FTID_IW              14
`define FTID_CLS_HI          13
`define FTID_CLS_LO          12
`define FTID_OP4_HI          11
`define FTID_OP4_LO          8
`define FTID_DEST_BIT        7
`define FTID_ADDR_HI         6
`define FTID_ADDR_LO         0
`define FTID_BIT_HI          9
`define FTID_BIT_LO          7
`define FTID_OP2_HI          11
`define FTID_OP2_LO          10
`define FTID_K11_HI          10
`define FTID_K8_HI           7
`define FTID_JMP_SEL         11
// classes
`define FTID_CLS_BYTE        2'h0
`define FTID_CLS_BIT         2'h1
`define FTID_CLS_JMP         2'h2
`define FTID_CLS_LIT         2'h3
// byte operation codes
`define FTID_B_MISC          4'h0
`define FTID_B_SUB           4'h2
`define FTID_B_CLR           4'h1
`define FTID_B_DEC           4'h3
`define FTID_B_OR            4'h4
`define FTID_B_AND           4'h5
`define FTID_B_XOR           4'h6
`define FTID_B_ADD           4'h7
`define FTID_B_MOV           4'h8
`define FTID_B_COM           4'h9
`define FTID_B_INC           4'ha
`define FTID_B_DECSKIP       4'hb
`define FTID_B_RR            4'hc
`define FTID_B_RL            4'hd
`define FTID_B_SWAP          4'he
`define FTID_B_INCSKIP       4'hf
// bit operation codes
`define FTID_T_CLR           2'h0
`define FTID_T_SET           2'h1
`define FTID_T_SKC           2'h2
`define FTID_T_SKS           2'h3
// fixed control words
`define FTID_W_RETURN        14'h0008
`define FTID_W_IRET          14'h0009
`define FTID_W_SLEEP         14'h0063
`define FTID_W_KICK          14'h0064
`define FTID_NOP_MASK        14'h3f9f
`define FTID_NOP_VAL         14'h0000
// timing and map
`define FTID_PHASES          2'h3
`define FTID_TMR_ADDR        7'h01
`define FTID_PORT_ADDR       7'h06
`define FTID_STAT_C          0
`define FTID_STAT_HA         1
`define FTID_STAT_Z          2
`endif

// File: logic/ftid_decoder.v
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "ftid_defines.vh"
module ftid_decoder (
   // clock, reset, enable
   input  wire        mclk,
   input  wire        rst,
   input  wire        ce,
   // instruction fetch
   input  wire [13:0] instr_word,
   output reg  [12:0] program_counter,
   // register file data
   input  wire [7:0]  reg_rdata,
   input  wire [7:0]  port_pins,
   input  wire        prescaler_on_timer,
   output reg  [6:0]  reg_addr,
   output reg         reg_rd,
   output reg         reg_wr,
   output reg  [7:0]  reg_wdata,
   output reg         prescaler_clr,
   // core state
   output reg  [7:0]  accumulator,
   output reg  [2:0]  status_flags,
   output reg         wdog_expiry_flag,
   output reg         sleep_entry_flag,
   output reg         sleeping,
   output reg         wdog_kick,
   output reg         gie_set,
   output reg  [2:0]  stack_depth
);
   // state
   reg  [1:0]  phase_r;
   reg  [13:0] ir_r;
   reg         flush_r;
   reg  [12:0] stack_r [0:7];
   reg  [7:0]  pins_s1_r;
   reg  [7:0]  pins_s2_r;
   reg  [2:0]  sp_r;
   // field split
   wire [1:0] cls   = ir_r[`FTID_CLS_HI:`FTID_CLS_LO];
   wire [3:0] op4   = ir_r[`FTID_OP4_HI:`FTID_OP4_LO];
   wire       dest  = ir_r[`FTID_DEST_BIT];
   wire [6:0] faddr = ir_r[`FTID_ADDR_HI:`FTID_ADDR_LO];
   wire [2:0] bidx  = ir_r[`FTID_BIT_HI:`FTID_BIT_LO];
   wire [1:0] op2   = ir_r[`FTID_OP2_HI:`FTID_OP2_LO];
   wire [7:0] k8    = ir_r[`FTID_K8_HI:0];
   wire [10:0] k11  = ir_r[`FTID_K11_HI:0];
   // operand read: port reads pin levels
   wire [7:0] fval = (faddr == `FTID_PORT_ADDR) ? pins_s2_r : reg_rdata;
   wire [7:0] bmask = 8'h01 << bidx;
   // execute result
   reg  [8:0] res;
   reg  [3:0] hsum;
   reg        to_acc;
   reg        to_reg;
   reg        upd_z;
   reg        upd_c;
   reg        skip;
   reg        is_jump;
   reg        is_call;
   reg        is_ret;
   reg        do_sleep;
   reg        do_kick;
   reg        do_iret;
   reg        uses_reg;
   always @* begin
      res      = 9'h000;
      hsum     = 4'h0;
      to_acc   = 1'b0;
      to_reg   = 1'b0;
      upd_z    = 1'b0;
      upd_c    = 1'b0;
      skip     = 1'b0;
      is_jump  = 1'b0;
      is_call  = 1'b0;
      is_ret   = 1'b0;
      do_sleep = 1'b0;
      do_kick  = 1'b0;
      do_iret  = 1'b0;
      uses_reg = 1'b0;
      case (cls)
         `FTID_CLS_BYTE: begin
            uses_reg = 1'b1;
            to_acc   = ~dest;
            to_reg   = dest;
            case (op4)
               `FTID_B_MISC: begin
                  if (dest) begin
                     res = {1'b0, accumulator};
                  end else begin
                     uses_reg = 1'b0;
                     to_acc   = 1'b0;
                     // fixed control words matched exactly, x bits masked only in the no-op check
                     if (ir_r == `FTID_W_RETURN) begin
                        is_ret = 1'b1;
                     end else if (ir_r == `FTID_W_IRET) begin
                        is_ret  = 1'b1;
                        do_iret = 1'b1;
                     end else if (ir_r == `FTID_W_SLEEP) begin
                        do_sleep = 1'b1;
                     end else if (ir_r == `FTID_W_KICK) begin
                        do_kick = 1'b1;
                     end else if ((ir_r & `FTID_NOP_MASK) == `FTID_NOP_VAL) begin
                        is_ret = 1'b0;
                     end
                  end
               end
               `FTID_B_CLR: begin
                  res      = 9'h000;
                  upd_z    = 1'b1;
                  uses_reg = dest;
               end
               `FTID_B_SUB: begin
                  res   = {1'b0, fval} + {1'b0, ~accumulator} + 9'h001;
                  hsum  = fval[3:0] + ~accumulator[3:0] + 4'h1;
                  upd_z = 1'b1;
                  upd_c = 1'b1;
               end
               `FTID_B_DEC: begin
                  res   = {1'b0, fval - 8'h01};
                  upd_z = 1'b1;
               end
               `FTID_B_OR: begin
                  res   = {1'b0, fval | accumulator};
                  upd_z = 1'b1;
               end
               `FTID_B_AND: begin
                  res   = {1'b0, fval & accumulator};
                  upd_z = 1'b1;
               end
               `FTID_B_XOR: begin
                  res   = {1'b0, fval ^ accumulator};
                  upd_z = 1'b1;
               end
               `FTID_B_ADD: begin
                  res   = {1'b0, fval} + {1'b0, accumulator};
                  hsum  = fval[3:0] + accumulator[3:0];
                  upd_z = 1'b1;
                  upd_c = 1'b1;
               end
               `FTID_B_MOV: begin
                  res   = {1'b0, fval};
                  upd_z = 1'b1;
               end
               `FTID_B_COM: begin
                  res   = {1'b0, ~fval};
                  upd_z = 1'b1;
               end
               `FTID_B_INC: begin
                  res   = {1'b0, fval + 8'h01};
                  upd_z = 1'b1;
               end
               `FTID_B_DECSKIP: begin
                  res  = {1'b0, fval - 8'h01};
                  skip = (fval == 8'h01);
               end
               `FTID_B_INCSKIP: begin
                  res  = {1'b0, fval + 8'h01};
                  skip = (fval == 8'hff);
               end
               `FTID_B_RR: begin
                  res = {fval[0], status_flags[`FTID_STAT_C], fval[7:1]};
               end
               `FTID_B_RL: begin
                  res = {fval[7], fval[6:0], status_flags[`FTID_STAT_C]};
               end
               default: begin
                  res = {1'b0, fval[3:0], fval[7:4]};
               end
            endcase
         end
         `FTID_CLS_BIT: begin
            uses_reg = 1'b1;
            case (op2)
               `FTID_T_CLR: begin
                  res    = {1'b0, fval & ~bmask};
                  to_reg = 1'b1;
               end
               `FTID_T_SET: begin
                  res    = {1'b0, fval | bmask};
                  to_reg = 1'b1;
               end
               `FTID_T_SKC: begin
                  skip = ~|(fval & bmask);
               end
               default: begin
                  skip = |(fval & bmask);
               end
            endcase
         end
         `FTID_CLS_JMP: begin
            is_jump = 1'b1;
            is_call = ~ir_r[`FTID_JMP_SEL];
         end
         // literal class: immediates, returns and arithmetic
         default: begin
            to_acc = 1'b1;
            casez (op4)
               4'b00??: res = {1'b0, k8};
               4'b01??: begin
                  res    = {1'b0, k8};
                  is_ret = 1'b1;
               end
               4'b1000: begin
                  res   = {1'b0, k8 | accumulator};
                  upd_z = 1'b1;
               end
               4'b1001: begin
                  res   = {1'b0, k8 & accumulator};
                  upd_z = 1'b1;
               end
               4'b1010: begin
                  res   = {1'b0, k8 ^ accumulator};
                  upd_z = 1'b1;
               end
               4'b110?: begin
                  res   = {1'b0, k8} + {1'b0, ~accumulator} + 9'h001;
                  hsum  = k8[3:0] + ~accumulator[3:0] + 4'h1;
                  upd_z = 1'b1;
                  upd_c = 1'b1;
               end
               4'b111?: begin
                  res   = {1'b0, k8} + {1'b0, accumulator};
                  hsum  = k8[3:0] + accumulator[3:0];
                  upd_z = 1'b1;
                  upd_c = 1'b1;
               end
               default: begin
                  to_acc = 1'b0;
               end
            endcase
         end
      endcase
   end
   // half carry: add forms look for nibble overflow,
   // subtract forms for no borrow out of the low nibble
   wire       lit_cls  = (cls == `FTID_CLS_LIT);
   wire [3:0] opnd_lo  = lit_cls ? k8[3:0] : fval[3:0];
   wire       add_form = lit_cls ? op4[1] : (op4 == `FTID_B_ADD);
   wire       half_c   = add_form ?
                         ((hsum < accumulator[3:0]) | (hsum < opnd_lo)) :
                         ~(opnd_lo < accumulator[3:0]);
   wire rot = (cls == `FTID_CLS_BYTE) && (op4 == `FTID_B_RR || op4 == `FTID_B_RL);
   wire redirect = skip | is_jump | is_ret;
   wire execute  = ce && !sleeping && phase_r == `FTID_PHASES;
   // pin synchroniser
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         pins_s1_r <= 8'h00;
         pins_s2_r <= 8'h00;
      end else if (ce) begin
         pins_s1_r <= port_pins;
         pins_s2_r <= pins_s1_r;
      end
   end
   // return stack
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_stk
         always @(posedge mclk or posedge rst) begin
            if (rst) begin
               stack_r[gi] <= 13'h0000;
            end else if (execute && !flush_r && is_call && sp_r == gi) begin
               stack_r[gi] <= program_counter;
            end
         end
      end
   endgenerate
   // sequencer and execute
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         phase_r          <= 2'h0;
         ir_r             <= 14'h0000;
         flush_r          <= 1'b1;
         sp_r             <= 3'h0;
         program_counter  <= 13'h0000;
         reg_addr         <= 7'h00;
         reg_rd           <= 1'b0;
         reg_wr           <= 1'b0;
         reg_wdata        <= 8'h00;
         prescaler_clr    <= 1'b0;
         accumulator      <= 8'h00;
         status_flags     <= 3'h0;
         wdog_expiry_flag <= 1'b1;
         sleep_entry_flag <= 1'b1;
         sleeping         <= 1'b0;
         wdog_kick        <= 1'b0;
         gie_set          <= 1'b0;
         stack_depth      <= 3'h0;
      end else if (ce) begin
         phase_r       <= phase_r + 2'h1;
         reg_wr        <= 1'b0;
         reg_rd        <= 1'b0;
         prescaler_clr <= 1'b0;
         wdog_kick     <= 1'b0;
         gie_set       <= 1'b0;
         if (phase_r == 2'h0) begin
            reg_addr <= faddr;
            reg_rd   <= uses_reg & ~flush_r;
         end
         if (execute) begin
            ir_r            <= instr_word;
            program_counter <= program_counter + 13'h0001;
            flush_r         <= 1'b0;
            // write-back and flag updates, skipped while flushing
            if (!flush_r) begin
               flush_r <= redirect;
               if (to_reg) begin
                  reg_wr    <= 1'b1;
                  reg_wdata <= res[7:0];
                  prescaler_clr <= (faddr == `FTID_TMR_ADDR) & prescaler_on_timer;
               end
               if (to_acc) begin
                  accumulator <= res[7:0];
               end
               if (upd_z) begin
                  status_flags[`FTID_STAT_Z] <= (res[7:0] == 8'h00);
               end
               if (upd_c) begin
                  status_flags[`FTID_STAT_C]  <= res[8];
                  status_flags[`FTID_STAT_HA] <= half_c;
               end
               if (rot) begin
                  status_flags[`FTID_STAT_C] <= res[8];
               end
               if (is_jump) begin
                  program_counter <= {2'h0, k11};
               end
               if (is_call) begin
                  sp_r        <= sp_r + 3'h1;
                  stack_depth <= sp_r + 3'h1;
               end
               if (is_ret) begin
                  program_counter <= stack_r[sp_r - 3'h1];
                  sp_r            <= sp_r - 3'h1;
                  stack_depth     <= sp_r - 3'h1;
                  gie_set         <= do_iret;
               end
               if (do_sleep) begin
                  sleeping         <= 1'b1;
                  wdog_expiry_flag <= 1'b1;
                  sleep_entry_flag <= 1'b0;
               end
               if (do_kick) begin
                  wdog_kick        <= 1'b1;
                  wdog_expiry_flag <= 1'b1;
                  sleep_entry_flag <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// File: verification/ftid_decoder_sva.sv
`timescale 1ns/10ps
// timing and side-effect checks on the decoder ports
module ftid_decoder_sva (
   // clock, reset, enable
   input wire        mclk,
   input wire        rst,
   input wire        ce,
   // observed state
   input wire [12:0] program_counter,
   input wire        prescaler_on_timer,
   input wire [6:0]  reg_addr,
   input wire        reg_rd,
   input wire        reg_wr,
   input wire        prescaler_clr,
   input wire [7:0]  accumulator,
   input wire [2:0]  status_flags,
   input wire        wdog_expiry_flag,
   input wire        sleep_entry_flag,
   input wire        sleeping,
   input wire        wdog_kick
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // three idle cycles, the rest of one four-cycle instruction slot
   sequence quiet3(s);
      !s [*3];
   endsequence
   // standby just entered
   sequence entered_sleep;
      $rose(sleeping);
   endsequence
   presc_clr_a: assert property (
      prescaler_clr == (reg_wr && reg_addr == 7'h01 && prescaler_on_timer))
      else $error("prescaler clear not tied to a timer write");
   rmw_read_a: assert property (
      reg_wr |-> $past(reg_rd, 3) && $past(reg_addr, 3) == reg_addr)
      else $error("register written without a prior read");
   wr_pulse_a: assert property (
      reg_wr |=> quiet3(reg_wr))
      else $error("write strobe closer than one instruction slot");
   rd_pulse_a: assert property (
      reg_rd |=> quiet3(reg_rd))
      else $error("read strobe closer than one instruction slot");
   standby_flags_a: assert property (
      entered_sleep |-> !sleep_entry_flag && wdog_expiry_flag)
      else $error("standby entry flags wrong");
   sleep_hold_a: assert property (
      sleeping |=> sleeping && $stable(program_counter) && !reg_wr)
      else $error("core moved while in standby");
   freeze_a: assert property (
      !ce |=> $stable(program_counter) && $stable(accumulator) && $stable(status_flags))
      else $error("state moved with enable low");
   pc_step_a: assert property (
      $changed(program_counter) |=> $stable(program_counter) [*3])
      else $error("fetch address moved twice in one slot");
   kick_flags_a: assert property (
      wdog_kick |-> wdog_expiry_flag && sleep_entry_flag)
      else $error("watchdog kick left a flag low");
endmodule
bind ftid_decoder ftid_decoder_sva chk (.mclk(mclk), .rst(rst), .ce(ce),
   .program_counter(program_counter), .prescaler_on_timer(prescaler_on_timer),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .prescaler_clr(prescaler_clr),
   .accumulator(accumulator), .status_flags(status_flags),
   .wdog_expiry_flag(wdog_expiry_flag), .sleep_entry_flag(sleep_entry_flag),
   .sleeping(sleeping), .wdog_kick(wdog_kick));

// File: verification/ftid_prog_mem.sv
`timescale 1ns/10ps
// program memory: combinational fetch of the word at the fetch address
module ftid_prog_mem (
   // fetch side
   input  wire [12:0] program_counter,
   output wire [13:0] instr_word
);
   logic [13:0] mem [256];
   // image is loaded by the bench while the core is held in reset
   assign instr_word = mem[program_counter[7:0]];
endmodule

// File: verification/fourteen_bit_instruction_decoder_test.sv
`timescale 1ns/10ps
module fourteen_bit_instruction_decoder_test;
   logic        mclk, rst, ce, prescaler_on_timer;
   logic [7:0]  port_pins;
   wire  [13:0] instr_word;
   wire  [12:0] program_counter;
   wire  [6:0]  reg_addr;
   wire         reg_rd, reg_wr, prescaler_clr, wdog_expiry_flag, sleep_entry_flag;
   wire         sleeping, wdog_kick, gie_set;
   wire  [7:0]  reg_wdata, accumulator;
   wire  [2:0]  status_flags, stack_depth;
   logic [7:0]  rf [128];
   logic [13:0] prog [256];
   int          fails = 0, cmp_count = 0, cycles = 0;
   int          m_acc, m_c, m_dc, m_z;
   int          m_rf [128];

   ftid_prog_mem pmem (.program_counter(program_counter), .instr_word(instr_word));
   ftid_decoder dut (.mclk(mclk), .rst(rst), .ce(ce), .instr_word(instr_word),
      .program_counter(program_counter), .reg_rdata(rf[reg_addr]), .port_pins(port_pins),
      .prescaler_on_timer(prescaler_on_timer), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .prescaler_clr(prescaler_clr),
      .accumulator(accumulator), .status_flags(status_flags),
      .wdog_expiry_flag(wdog_expiry_flag), .sleep_entry_flag(sleep_entry_flag),
      .sleeping(sleeping), .wdog_kick(wdog_kick), .gie_set(gie_set),
      .stack_depth(stack_depth));

   // clock
   initial begin
      mclk = 0;
      forever #4 mclk = ~mclk;
   end
   // register file and hang guard
   always @(posedge mclk) begin
      if (reg_wr) rf[reg_addr] <= reg_wdata;
      cycles++;
      if (cycles == 20000) begin
         fails++;
         results();
      end
   end

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // reference execution of the loaded image up to the standby word
   task automatic model_run();
      int pc, w, f, v, r, k, bt, op, sp;
      int stk [8];
      pc = 0;
      sp = 0;
      while (prog[pc] !== 14'h0063) begin
         w = prog[pc];
         pc++;
         f = w & 'h7f;
         k = w & 'hff;
         bt = w >> 7 & 7;
         op = w >> 8 & 15;
         v = (f == 6) ? port_pins : m_rf[f];
         case (w >> 12)
            0: begin
               case (op)
                  1: r = 0;
                  2: r = v - m_acc;
                  3: r = v - 1;
                  8: r = v;
                  10: r = v + 1;
                  14: r = (v >> 4 | v << 4) & 255;
                  4: r = v | m_acc;
                  5: r = v & m_acc;
                  6: r = v ^ m_acc;
                  7: r = v + m_acc;
                  9: r = ~v;
                  11: r = v - 1;
                  12: r = m_c << 7 | v >> 1;
                  13: r = v << 1 | m_c;
                  15: r = v + 1;
                  default: r = m_acc;
               endcase
               if (op == 2 || op == 7) begin
                  m_c = (op == 7) ? r > 255 : v >= m_acc;
                  m_dc = (op == 7) ? (v & 15) + (m_acc & 15) > 15 : (v & 15) >= (m_acc & 15);
               end
               if (op == 12 || op == 13) m_c = (op == 12) ? v & 1 : v >> 7 & 1;
               r = r & 255;
               if (op inside {[1:10]}) m_z = (r == 0);
               if ((op == 11 || op == 15) && r == 0) pc++;
               if (w & 'h80) m_rf[f] = r;
               else if (op != 0) m_acc = r;
            end
            1: begin
               case (op >> 2)
                  0: m_rf[f] = v & ~(1 << bt) & 255;
                  1: m_rf[f] = v | 1 << bt;
                  2: pc += (v >> bt & 1) ^ 1;
                  default: pc += v >> bt & 1;
               endcase
            end
            2: begin
               if (!(w >> 11 & 1)) begin
                  stk[sp] = pc;
                  sp++;
               end
               pc = w & 'h7ff;
            end
            default: begin
               if (op == 12 || op == 13) begin
                  m_c = k >= m_acc;
                  m_dc = (k & 15) >= (m_acc & 15);
               end
               if (op >= 14) begin
                  m_c = (k + m_acc) > 255;
                  m_dc = (k & 15) + (m_acc & 15) > 15;
               end
               if (op >> 2 == 1) begin
                  sp--;
                  pc = stk[sp];
               end
               case (op)
                  8: m_acc = k | m_acc;
                  9: m_acc = k & m_acc;
                  10: m_acc = k ^ m_acc;
                  11: m_acc = m_acc;
                  12, 13: m_acc = (k - m_acc) & 255;
                  14, 15: m_acc = (k + m_acc) & 255;
                  default: m_acc = k;
               endcase
               if (op >= 8 && op != 11) m_z = (m_acc == 0);
            end
         endcase
      end
   endtask

   // main sequence: several runs of one image with random operands
   initial begin
      int a, b, c, rb, x, n;
      int img [27];
      rst = 1;
      ce = 0;
      port_pins = 8'h00;
      prescaler_on_timer = 0;
      void'($urandom(45));
      repeat (10) @(posedge mclk);
      for (int run = 0; run < 4; run++) begin
         rst <= 1;
         a = $urandom % 256;
         b = $urandom % 256;
         c = $urandom % 256;
         rb = $urandom % 8;
         x = $urandom % 4;
         port_pins <= 8'($urandom);
         prescaler_on_timer <= 1'($urandom);
         img = '{'h3000 | x << 8 | a, 'h00a0, 'h3000 | b, 'h0720, 'h00a1, 'h02a0, 'h0da1,
            'h0c21, 'h0fa2, 'h3055, 'h0ba4, 'h3066, 'h1423 | rb << 7, 'h1823 | rb << 7,
            'h2028, 'h3a00 | b, 'h3c00 | (x & 1) << 8 | a, 'h0064, 'h04a3, 'h0623, 'h0523,
            'h0986, 'h0081, 'h1c23 | rb << 7, 'h3077, x << 5, 'h0063};
         for (int i = 0; i < 256; i++) prog[i] = 14'h0063;
         for (int i = 0; i < 27; i++) prog[i] = 14'(img[i]);
         prog[40] = 14'('h3400 | x << 8 | c);
         for (int i = 0; i < 256; i++) pmem.mem[i] = prog[i];
         for (int i = 0; i < 128; i++) rf[i] = 8'($urandom);
         if (run[0]) rf[34] = 8'hff;
         if (run[1]) rf[36] = 8'h01;
         for (int i = 0; i < 128; i++) m_rf[i] = rf[i];
         repeat (10) @(posedge mclk);
         rst <= 0;
         repeat ($urandom % 6) @(posedge mclk);
         ce <= 1;
         n = 0;
         while (sleeping !== 1'b1 && n < 600) begin
            @(posedge mclk);
            n++;
         end
         repeat (4) @(posedge mclk);
         @(negedge mclk);
         m_acc = 0;
         m_c = 0;
         m_dc = 0;
         m_z = 0;
         @(negedge mclk);
         model_run();
         chk("accumulator", 8'(m_acc), accumulator);
         chk("status_flags", 8'(m_z * 4 + m_dc * 2 + m_c), {5'h0, status_flags});
         for (int i = 32; i < 37; i++) chk("reg_file", 8'(m_rf[i]), rf[i]);
         chk("port_reg", 8'(m_rf[6]), rf[6]);
         chk("standby_flags", 8'h05, {5'h0, sleeping, sleep_entry_flag, wdog_expiry_flag});
         chk("stack_depth", 8'h00, {5'h0, stack_depth});
         ce <= 0;
      end
      results();
   end
endmodule
